// *** design/sdp_command_port.sv ***
// Purpose: command layer of the single-wire debug port
// Assumes: core signals share clk_sys; mem_rdata valid from the cycle after
//   mem_rd until the reply is loaded
// Notes: speed probe and bit timing in sdp_bit_engine
// Contract
// - commands start with an 8-bit code; all fields go MSB first
// - non-intrusive commands always; register, step and resume only halted
// - each delay slot lasts 16 debug clock cycles
// - 0xD5 turns acknowledge on, 0xD6 turns it off, any state
// - 0x90 halts the processor only when background enable is set
// - 0xE4 returns status/control; 0xC4 loads it from host
// - 0xE0 takes address, waits a slot, returns memory byte
// - 0xE1 like 0xE0 but status byte precedes the data byte
// - 0xE8 returns status then byte re-read from last read address
// - 0xC0 takes address and byte, writes it during the slot
// - 0xC1 like 0xC0, then returns the status byte
// - 0xE2 returns 16-bit match register, 0xC2 loads it, no slot
// - 0x08 and 0x18 resume user code from current program counter
// - 0x10 runs one instruction then halts again
// - halted: slot then return accumulator, flags, counter, index, stack
// - halted: load those registers from host data, then a slot
// - 0x70 increments index, slot, returns byte; 0x71 adds status first
// - 0x50 increments index, writes byte in slot; 0x51 then status
// - on probe: wait for high, wait 16, drive low 128 cycles
// - after the probe pulse drive high one cycle, then release
// - each bit is 16 cycles and starts with a host falling edge
// - 512 cycles without host edge aborts the command harmlessly
// - received bit is sampled ten cycles after the perceived edge
// - sent zero holds the pin low 13 cycles then speedup pulse
`timescale 1ns/1ps
`default_nettype none
module sdp_command_port (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic debug_pin_in,
  output logic debug_pin_out,
  output logic debug_pin_oe,
  input wire logic halted_debug_mode,
  output logic halt_req,
  output logic resume_req,
  output logic step_req,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic reg_wr,
  output sdp_pkg::sdp_reg_sel_type reg_sel,
  output logic [15:0] reg_wdata,
  input wire logic [7:0] cpu_acc,
  input wire logic [7:0] condition_flags,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] cpu_index,
  input wire logic [15:0] stack_pointer,
  output logic [7:0] debug_status_control,
  output logic [15:0] debug_breakpoint_match,
  output logic ack_enabled
);
  import sdp_pkg::*;

  logic pin_level;
  logic bit_done;
  logic rx_bit;
  logic timeout;
  logic sync_seen;
  sdp_cmd_state_type state;
  sdp_cmd_state_type next_state;
  logic [7:0] cmd;
  logic [15:0] shift;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] last_addr;
  logic [4:0] bit_cnt;
  logic [7:0] dly_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // pin front end
  sdp_pin_sync #(
    .RESET_LEVEL(1'b1)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_async(debug_pin_in),
    .level(pin_level)
  );

  wire rx_phase = (state == S_CMD) | (state == S_ADDR) | (state == S_DATA);
  wire tx_phase = (state == S_STAT) | (state == S_TXD);

  sdp_bit_engine u_engine (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_level(pin_level),
    .tx_active(tx_phase),
    .tx_bit(shift[15]),
    .bit_done(bit_done),
    .rx_bit(rx_bit),
    .timeout(timeout),
    .sync_seen(sync_seen),
    .pin_out(debug_pin_out),
    .pin_oe(debug_pin_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // command decode
  wire [7:0] code = (state == S_CMD) ? {shift[6:0], rx_bit} : cmd;
  wire [15:0] rx_word = {shift[14:0], rx_bit};
  wire is_ack_on = (code == CMD_ACK_ON);
  wire is_ack_off = (code == CMD_ACK_OFF);
  wire is_halt = (code == CMD_HALT);
  wire is_stat = (code == CMD_STAT_FETCH);
  wire is_ctrl = (code == CMD_CTRL_LOAD);
  wire is_mrd = (code == CMD_MEM_FETCH);
  wire is_mrd_s = (code == CMD_MEM_FETCH_STAT);
  wire is_refetch = (code == CMD_MEM_REFETCH);
  wire is_mwr = (code == CMD_MEM_STORE);
  wire is_mwr_s = (code == CMD_MEM_STORE_STAT);
  wire is_mfetch = (code == CMD_MATCH_FETCH);
  wire is_mload = (code == CMD_MATCH_LOAD);
  wire is_resume = (code == CMD_RESUME) | (code == CMD_RESUME_TAGGED);
  wire is_step = (code == CMD_SINGLE_STEP);
  wire is_inc_rd_s = (code == CMD_AUTOINC_FETCH_STAT);
  wire is_inc_wr_s = (code == CMD_AUTOINC_STORE_STAT);
  wire c_mem_rd = is_mrd | is_mrd_s;
  wire c_mem_wr = is_mwr | is_mwr_s;
  wire c_inc_rd = (code == CMD_AUTOINC_FETCH) | is_inc_rd_s;
  wire c_inc_wr = (code == CMD_AUTOINC_STORE) | is_inc_wr_s;
  wire c_rd8 = (code == CMD_ACC_FETCH) | (code == CMD_FLAGS_FETCH);
  wire c_rd16 = (code == CMD_PROGCTR_FETCH) | (code == CMD_INDEX_FETCH) |
                (code == CMD_STACKPTR_FETCH);
  wire c_wr8 = (code == CMD_ACC_LOAD) | (code == CMD_FLAGS_LOAD);
  wire c_wr16 = (code == CMD_PROGCTR_LOAD) | (code == CMD_INDEX_LOAD) |
                (code == CMD_STACKPTR_LOAD);
  wire halted_only = c_inc_rd | c_inc_wr | c_rd8 | c_rd16 | c_wr8 | c_wr16 |
                     is_resume | is_step;
  wire no_slot = is_stat | is_ctrl | is_refetch | is_mfetch | is_mload;
  wire known = halted_only | no_slot | is_ack_on | is_ack_off | is_halt |
               c_mem_rd | c_mem_wr;
  wire accept = known & (~halted_only | halted_debug_mode);

  // phase layout of the accepted command
  wire has_addr = c_mem_rd | c_mem_wr;
  wire has_data = c_mem_wr | c_inc_wr | c_wr8 | c_wr16 | is_ctrl | is_mload;
  wire has_dly = known & ~no_slot;
  wire has_stat = is_stat | is_mrd_s | is_mwr_s | is_refetch | is_inc_rd_s |
                  is_inc_wr_s;
  wire has_txd = c_mem_rd | is_refetch | c_inc_rd | c_rd8 | c_rd16 | is_mfetch;
  wire [4:0] data_len = (c_wr16 | is_mload) ? LEN_WORD : LEN_BYTE;
  wire [4:0] tx_len = (c_rd16 | is_mfetch) ? LEN_WORD : LEN_BYTE;

  sdp_cmd_state_type after_stat;
  sdp_cmd_state_type after_dly;
  sdp_cmd_state_type after_data;
  sdp_cmd_state_type after_addr;
  sdp_cmd_state_type after_cmd;
  assign after_stat = has_txd ? S_TXD : S_CMD;
  assign after_dly = has_stat ? S_STAT : after_stat;
  assign after_data = has_dly ? S_DELAY : after_dly;
  assign after_addr = has_data ? S_DATA : after_data;
  assign after_cmd = has_addr ? S_ADDR : after_addr;

  wire [4:0] phase_len = (state == S_ADDR) ? LEN_WORD :
                         (state == S_DATA) ? data_len :
                         (state == S_TXD) ? tx_len : LEN_BYTE;
  wire shifting = rx_phase | tx_phase;
  wire phase_end = bit_done & shifting & (bit_cnt == phase_len - 5'h01);
  wire dly_end = (state == S_DELAY) &
                 (dly_cnt == DELAY_SLOT_CYCLES - 8'h01);
  wire abort = timeout | sync_seen;
  wire cmd_end = (state == S_CMD) & phase_end & ~abort;
  wire data_end = (state == S_DATA) & phase_end & ~abort;
  wire act = (state == S_DELAY) & (dly_cnt == 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  // reply sources
  wire [15:0] inc_index = cpu_index + 16'h0001;
  wire [7:0] status_byte = (debug_status_control & ~HALTED_MASK) |
                           (halted_debug_mode ? HALTED_MASK : 8'h00);
  wire bgnd_en = |(debug_status_control & BGND_ENABLE_MASK);
  sdp_reg_sel_type code_sel;
  assign code_sel = (c_inc_rd | c_inc_wr) ? REG_INDEX :
                    (code[3:0] == 4'h8) ? REG_ACC :
                    (code[3:0] == 4'h9) ? REG_FLAGS :
                    (code[3:0] == 4'hB) ? REG_PROGCTR :
                    (code[3:0] == 4'hC) ? REG_INDEX : REG_STACKPTR;
  wire [15:0] reg16 = (code_sel == REG_PROGCTR) ? program_counter :
                      (code_sel == REG_INDEX) ? cpu_index : stack_pointer;
  wire [7:0] reg8 = (code_sel == REG_ACC) ? cpu_acc : condition_flags;
  wire [15:0] tx_source = c_rd16 ? reg16 :
                          is_mfetch ? debug_breakpoint_match :
                          c_rd8 ? {reg8, 8'h00} :
                          {mem_rdata, 8'h00};
  wire enter_stat = (next_state == S_STAT) & (state != S_STAT);
  wire enter_txd = (next_state == S_TXD) & (state != S_TXD);

  //////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    next_state = state;
    case (state)
      S_CMD: if (phase_end) next_state = accept ? after_cmd : S_CMD;
      S_ADDR: if (phase_end) next_state = after_addr;
      S_DATA: if (phase_end) next_state = after_data;
      S_DELAY: if (dly_end) next_state = after_dly;
      S_STAT: if (phase_end) next_state = after_stat;
      S_TXD: if (phase_end) next_state = S_CMD;
      default: next_state = S_CMD;
    endcase
    if (abort) begin
      next_state = S_CMD;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= S_CMD;
      cmd <= 8'h00;
      bit_cnt <= 5'h00;
      dly_cnt <= 8'h00;
    end else begin
      state <= next_state;
      if (cmd_end) begin
        cmd <= code;
      end
      if (abort | phase_end) begin
        bit_cnt <= 5'h00;
      end else if (bit_done & shifting) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      dly_cnt <= (state == S_DELAY) ? dly_cnt + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift <= 16'h0000;
      addr <= 16'h0000;
      wdata <= 16'h0000;
    end else begin
      if (abort) begin
        shift <= 16'h0000;
      end else if (enter_stat) begin
        shift <= {status_byte, 8'h00};
      end else if (enter_txd) begin
        shift <= tx_source;
      end else if (bit_done & rx_phase) begin
        shift <= rx_word;
      end else if (bit_done & tx_phase) begin
        shift <= {shift[14:0], 1'b0};
      end
      if ((state == S_ADDR) & phase_end & ~abort) begin
        addr <= rx_word;
      end
      if (data_end) begin
        wdata <= rx_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // debug registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      debug_status_control <= STATUS_CONTROL_RESET;
      debug_breakpoint_match <= MATCH_RESET;
      ack_enabled <= 1'b0;
    end else begin
      if (data_end & is_ctrl) begin
        debug_status_control <= rx_word[7:0];
      end
      if (data_end & is_mload) begin
        debug_breakpoint_match <= rx_word;
      end
      if (act & is_ack_on) begin
        ack_enabled <= 1'b1;
      end else if (act & is_ack_off) begin
        ack_enabled <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core side actions, issued on the first cycle of the slot; the 0xE8 read is issued at command end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      last_addr <= 16'h0000;
      reg_wr <= 1'b0;
      reg_sel <= REG_ACC;
      reg_wdata <= 16'h0000;
      halt_req <= 1'b0;
      resume_req <= 1'b0;
      step_req <= 1'b0;
    end else begin
      mem_rd <= (act & (c_mem_rd | c_inc_rd)) |
                (cmd_end & accept & is_refetch);
      mem_wr <= act & (c_mem_wr | c_inc_wr);
      reg_wr <= act & (c_wr8 | c_wr16 | c_inc_rd | c_inc_wr);
      halt_req <= act & is_halt & bgnd_en;
      resume_req <= act & is_resume;
      step_req <= act & is_step;
      if (cmd_end & accept & is_refetch) begin
        mem_addr <= last_addr;
      end else if (act) begin
        mem_addr <= (c_inc_rd | c_inc_wr) ? inc_index : addr;
        mem_wdata <= wdata[7:0];
        reg_sel <= code_sel;
        reg_wdata <= (c_inc_rd | c_inc_wr) ? inc_index : wdata;
      end
      if (act & (c_mem_rd | c_inc_rd)) begin
        last_addr <= (c_inc_rd) ? inc_index : addr;
      end
    end
  end
endmodule : sdp_command_port
`default_nettype wire

// *** design/sdp_pkg.sv ***
// Purpose: shared constants and types of the single-wire debug port
// Assumes: one debug clock clk_sys, counts given in debug clock cycles
// Notes: command codes, bit timing and reset values live here only
package sdp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] CMD_ACK_ON = 8'hD5;
  localparam logic [7:0] CMD_ACK_OFF = 8'hD6;
  localparam logic [7:0] CMD_HALT = 8'h90;
  localparam logic [7:0] CMD_STAT_FETCH = 8'hE4;
  localparam logic [7:0] CMD_CTRL_LOAD = 8'hC4;
  localparam logic [7:0] CMD_MEM_FETCH = 8'hE0;
  localparam logic [7:0] CMD_MEM_FETCH_STAT = 8'hE1;
  localparam logic [7:0] CMD_MEM_REFETCH = 8'hE8;
  localparam logic [7:0] CMD_MEM_STORE = 8'hC0;
  localparam logic [7:0] CMD_MEM_STORE_STAT = 8'hC1;
  localparam logic [7:0] CMD_MATCH_FETCH = 8'hE2;
  localparam logic [7:0] CMD_MATCH_LOAD = 8'hC2;
  localparam logic [7:0] CMD_RESUME = 8'h08;
  localparam logic [7:0] CMD_RESUME_TAGGED = 8'h18;
  localparam logic [7:0] CMD_SINGLE_STEP = 8'h10;
  localparam logic [7:0] CMD_ACC_FETCH = 8'h68;
  localparam logic [7:0] CMD_FLAGS_FETCH = 8'h69;
  localparam logic [7:0] CMD_PROGCTR_FETCH = 8'h6B;
  localparam logic [7:0] CMD_INDEX_FETCH = 8'h6C;
  localparam logic [7:0] CMD_STACKPTR_FETCH = 8'h6F;
  localparam logic [7:0] CMD_AUTOINC_FETCH = 8'h70;
  localparam logic [7:0] CMD_AUTOINC_FETCH_STAT = 8'h71;
  localparam logic [7:0] CMD_ACC_LOAD = 8'h48;
  localparam logic [7:0] CMD_FLAGS_LOAD = 8'h49;
  localparam logic [7:0] CMD_PROGCTR_LOAD = 8'h4B;
  localparam logic [7:0] CMD_INDEX_LOAD = 8'h4C;
  localparam logic [7:0] CMD_STACKPTR_LOAD = 8'h4F;
  localparam logic [7:0] CMD_AUTOINC_STORE = 8'h50;
  localparam logic [7:0] CMD_AUTOINC_STORE_STAT = 8'h51;

  //////////////////////////////////////////////////////////////////////////////
  // bit and slot timing, in debug clock cycles
  localparam logic [7:0] BIT_SAMPLE_CYCLES = 8'h0A;
  localparam logic [7:0] ONE_SPEEDUP_AT = 8'h07;
  localparam logic [7:0] ZERO_LOW_CYCLES = 8'h0D;
  localparam logic [7:0] DELAY_SLOT_CYCLES = 8'h10;
  localparam logic [7:0] SYNC_GAP_CYCLES = 8'h10;
  localparam logic [7:0] SYNC_PULSE_CYCLES = 8'h80;
  localparam logic [7:0] SYNC_DETECT_CYCLES = 8'h80;
  localparam logic [9:0] TIMEOUT_CYCLES = 10'h200;

  //////////////////////////////////////////////////////////////////////////////
  // field lengths, reset values, status layout
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_WORD = 5'h10;
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [7:0] BGND_ENABLE_MASK = 8'h80;
  localparam logic [7:0] HALTED_MASK = 8'h40;

  typedef logic [2:0] sdp_reg_sel_type;
  localparam sdp_reg_sel_type REG_ACC = 3'h0;
  localparam sdp_reg_sel_type REG_FLAGS = 3'h1;
  localparam sdp_reg_sel_type REG_PROGCTR = 3'h2;
  localparam sdp_reg_sel_type REG_INDEX = 3'h3;
  localparam sdp_reg_sel_type REG_STACKPTR = 3'h4;

  typedef enum logic [5:0] {
    E_IDLE = 6'h01,
    E_BIT = 6'h02,
    E_WAITHI = 6'h04,
    E_GAP = 6'h08,
    E_LOW = 6'h10,
    E_SPEED = 6'h20
  } sdp_eng_state_type;

  typedef enum logic [5:0] {
    S_CMD = 6'h01,
    S_ADDR = 6'h02,
    S_DATA = 6'h04,
    S_DELAY = 6'h08,
    S_STAT = 6'h10,
    S_TXD = 6'h20
  } sdp_cmd_state_type;

endpackage : sdp_pkg

// *** design/sdp_pin_sync.sv ***
// Purpose: three-stage synchroniser for the debug pin level
// Assumes: pin is asynchronous to clk_sys
// Notes: level changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sdp_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_async,
  output logic level
);
  logic ff1;
  logic ff2;
  logic ff3;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ff1 <= RESET_LEVEL;
      ff2 <= RESET_LEVEL;
      ff3 <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else begin
      ff1 <= pin_async;
      ff2 <= ff1;
      ff3 <= ff2;
      if (ff2 == ff3) begin
        level <= ff3;
      end
    end
  end
endmodule : sdp_pin_sync
`default_nettype wire

// *** design/sdp_bit_engine.sv ***
// Purpose: bit timing, speed probe reply and inter-edge timeout
// Assumes: pin_level already synchronised
// Notes: pin_out and pin_oe are registered, one cycle behind the state
`timescale 1ns/1ps
`default_nettype none
module sdp_bit_engine (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_level,
  input wire logic tx_active,
  input wire logic tx_bit,
  output logic bit_done,
  output logic rx_bit,
  output logic timeout,
  output logic sync_seen,
  output logic pin_out,
  output logic pin_oe
);
  import sdp_pkg::*;

  sdp_eng_state_type state;
  sdp_eng_state_type next_state;
  logic [7:0] cnt;
  logic [7:0] low_cnt;
  logic [9:0] gap;
  logic pin_prev;
  logic tx_dir;
  logic tx_val;

  //////////////////////////////////////////////////////////////////////////////
  // decode
  wire fall = pin_prev & ~pin_level;
  wire in_sync = (state == E_WAITHI) | (state == E_GAP) |
                 (state == E_LOW) | (state == E_SPEED);
  wire start = (state == E_IDLE) & fall;
  wire low_trip = ~pin_level & ~in_sync &
                  (low_cnt == SYNC_DETECT_CYCLES - 8'h01);
  wire rx_end = (cnt == BIT_SAMPLE_CYCLES);
  wire rx_done = (cnt == BIT_SAMPLE_CYCLES + 8'h01);
  wire tx_end = (cnt == ZERO_LOW_CYCLES);
  wire bit_end = (state == E_BIT) & (tx_dir ? tx_end : rx_done);
  wire drive_zero = tx_dir & ~tx_val & (cnt < ZERO_LOW_CYCLES);
  wire drive_one = tx_dir & (tx_val ? (cnt == ONE_SPEEDUP_AT) : tx_end);
  wire bit_oe = ((state == E_BIT) & (drive_zero | drive_one)) |
                (start & tx_active & ~tx_bit);
  wire next_oe = bit_oe | (state == E_LOW) | (state == E_SPEED);
  wire next_out = ((state == E_BIT) & drive_one) | (state == E_SPEED);

  assign bit_done = bit_end;
  assign sync_seen = low_trip;
  assign timeout = (gap == TIMEOUT_CYCLES - 10'h001) & ~start;

  always_comb begin
    next_state = state;
    case (state)
      E_IDLE: if (start) next_state = E_BIT;
      E_BIT: if (bit_end) next_state = E_IDLE;
      E_WAITHI: if (pin_level) next_state = E_GAP;
      E_GAP: if (cnt == SYNC_GAP_CYCLES - 8'h01) next_state = E_LOW;
      E_LOW: if (cnt == SYNC_PULSE_CYCLES - 8'h01) next_state = E_SPEED;
      E_SPEED: next_state = E_IDLE;
      default: next_state = E_IDLE;
    endcase
    if (low_trip) begin
      next_state = E_WAITHI;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state and counters
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= E_IDLE;
      cnt <= 8'h00;
      pin_prev <= 1'b1;
    end else begin
      state <= next_state;
      pin_prev <= pin_level;
      if (next_state != state) begin
        cnt <= start ? 8'h01 : 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      low_cnt <= 8'h00;
      gap <= 10'h000;
    end else begin
      if (pin_level | in_sync) begin
        low_cnt <= 8'h00;
      end else if (low_cnt != SYNC_DETECT_CYCLES - 8'h01) begin
        low_cnt <= low_cnt + 8'h01;
      end
      if (start) begin
        gap <= 10'h000;
      end else if (gap != TIMEOUT_CYCLES) begin
        gap <= gap + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_dir <= 1'b0;
      tx_val <= 1'b0;
      rx_bit <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      if (start) begin
        tx_dir <= tx_active;
        tx_val <= tx_bit;
      end
      if ((state == E_BIT) & ~tx_dir & rx_end) begin
        rx_bit <= pin_level;
      end
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end
endmodule : sdp_bit_engine
`default_nettype wire

// *** dv/sdp_host_model.sv ***
// Purpose: debug pod model driving the debug wire
// Assumes: wire is pulled up while nobody drives it
// Notes: drives low only, one bit every 25 cycles
`timescale 1ns/1ps
`default_nettype none
module sdp_host_model (
  input wire logic clk_sys,
  input wire logic pin,
  output logic host_low
);
  initial host_low = 1'b0;
  task automatic bit_io(input logic b, output logic s);
    @(negedge clk_sys) host_low = 1'b1;
    repeat (4) @(negedge clk_sys);
    host_low = !b;
    repeat (8) @(negedge clk_sys);
    s = pin;
    repeat (4) @(negedge clk_sys);
    host_low = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask : bit_io
  task automatic xfer8(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit_io(t[i], r[i]);
  endtask : xfer8
  // long low, release, then time the reply
  task automatic probe(output logic [15:0] n);
    n = 16'h0000;
    @(negedge clk_sys) host_low = 1'b1;
    repeat (150) @(negedge clk_sys);
    host_low = 1'b0;
    repeat (200) begin
      @(negedge clk_sys);
      if (pin === 1'b0) n++;
    end
  endtask : probe
endmodule : sdp_host_model
`default_nettype wire

// *** dv/sdp_command_port_checker.sv ***
// Purpose: port assertions of the command port
// Assumes: one clock, async reset
// Notes: bound into sdp_command_port
`timescale 1ns/1ps
`default_nettype none
module sdp_command_port_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic debug_pin_out,
  input wire logic debug_pin_oe,
  input wire logic halted_debug_mode,
  input wire logic halt_req,
  input wire logic resume_req,
  input wire logic step_req,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic reg_wr,
  input wire logic [7:0] debug_status_control
);
  import sdp_pkg::*;
  logic low_drv;
  logic [8:0] low_cnt;
  assign low_drv = debug_pin_oe && !debug_pin_out;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) low_cnt <= 9'h000;
    else low_cnt <= low_drv ? low_cnt + 9'h001 : 9'h000;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_low_len: assert property ($fell(low_drv) |->
    low_cnt == 9'h00D || low_cnt == 9'h080) else $error("low drive length");
  chk_speedup: assert property ($fell(low_drv) |->
    debug_pin_oe && debug_pin_out) else $error("no speedup pulse");
  chk_speedup_one: assert property (debug_pin_oe && debug_pin_out
    |=> !debug_pin_oe) else $error("speedup too long");
  chk_halt_enable: assert property (halt_req
    |-> debug_status_control[7]) else $error("halt without enable");
  chk_resume_halted: assert property (resume_req
    |-> halted_debug_mode) else $error("resume while running");
  chk_step_halted: assert property (step_req
    |-> halted_debug_mode) else $error("step while running");
  chk_regwr_halted: assert property (reg_wr
    |-> halted_debug_mode) else $error("reg write while running");
  chk_wr_alone: assert property (mem_wr
    |-> !mem_rd && !debug_pin_oe) else $error("write overlaps");
  chk_wr_pulse: assert property (mem_wr |=> !mem_wr)
    else $error("write not a pulse");
endmodule : sdp_command_port_checker
bind sdp_command_port sdp_command_port_checker u_sdp_command_port_checker (
  .clk_sys, .reset, .debug_pin_out, .debug_pin_oe, .halted_debug_mode,
  .halt_req, .resume_req, .step_req, .mem_rd, .mem_wr, .reg_wr,
  .debug_status_control);
`default_nettype wire

// *** dv/sdp_command_port_tb.sv ***
// Purpose: self-checking bench of the command port
// Assumes: core registers held at fixed values
// Notes: memory reads return address low byte xor A5
`timescale 1ns/1ps
`default_nettype none
module sdp_command_port_tb;
  import sdp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic halted_debug_mode = 1'b0;
  logic host_low, pin, debug_pin_out, debug_pin_oe, halt_req, resume_req;
  logic step_req, mem_rd, mem_wr, reg_wr, ack_enabled;
  logic [15:0] mem_addr, reg_wdata, debug_breakpoint_match, wa, rw;
  logic [7:0] mem_wdata, mem_rdata, debug_status_control, wd, r, h;
  sdp_reg_sel_type reg_sel, rs;
  logic [15:0] n_errors = 16'h0000, checks_done = 16'h0000, n;
  logic [15:0] n_halt = 16'h0000, n_res = 16'h0000, n_step = 16'h0000;
  always #4 clk_sys = !clk_sys;
  assign pin = debug_pin_oe ? debug_pin_out : !host_low;
  assign mem_rdata = mem_addr[7:0] ^ 8'hA5;
  always @(posedge clk_sys) begin
    if (mem_wr) {wa, wd} <= {mem_addr, mem_wdata};
    if (reg_wr) {rs, rw} <= {reg_sel, reg_wdata};
    n_halt <= n_halt + {15'h0000, halt_req};
    n_res <= n_res + {15'h0000, resume_req};
    n_step <= n_step + {15'h0000, step_req};
  end
  sdp_command_port u_sdp_command_port (.clk_sys, .reset, .debug_pin_in(pin),
    .debug_pin_out, .debug_pin_oe, .halted_debug_mode, .halt_req, .resume_req,
    .step_req, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .reg_wr,
    .reg_sel, .reg_wdata, .cpu_acc(8'h3C), .condition_flags(8'h5A),
    .program_counter(16'h1234), .cpu_index(16'h2000),
    .stack_pointer(16'h00FF), .debug_status_control, .debug_breakpoint_match,
    .ack_enabled);
  sdp_host_model u_sdp_host_model (.clk_sys, .pin, .host_low);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic x8(input logic [7:0] t);
    u_sdp_host_model.xfer8(t, r);
  endtask : x8
  task automatic slot;
    repeat (20) @(negedge clk_sys);
  endtask : slot
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 16'h0000 && checks_done != 16'h0000) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_probe;
    x8(8'hE0);
    u_sdp_host_model.probe(n);
    chk("probe low", 16'h0080, n);
    x8(8'hE4);
    x8(8'hFF);
    chk("status", 16'h0000, {8'h00, r});
    $display("probe test done");
  endtask : t_probe
  task automatic t_ctrl;
    x8(8'hC4); x8(8'h00); x8(8'h90); slot;
    chk("halt off", 16'h0000, n_halt);
    x8(8'hC4); x8(8'h81); x8(8'h90); slot;
    chk("halt on", 16'h0001, n_halt);
    x8(8'h68); x8(8'hE4); x8(8'hFF);
    chk("status", 16'h0081, {8'h00, r});
    $display("control test done");
  endtask : t_ctrl
  task automatic t_mem;
    x8(8'hC0); x8(8'h12); x8(8'h34); x8(8'h9C); slot;
    chk("wr addr", 16'h1234, wa);
    chk("wr data", 16'h009C, {8'h00, wd});
    x8(8'hE1); x8(8'hAB); x8(8'hCD); slot; x8(8'hFF); h = r; x8(8'hFF);
    chk("e1 reply", 16'h8168, {h, r});
    x8(8'hE8); x8(8'hFF); h = r; x8(8'hFF);
    chk("e8 reply", 16'h8168, {h, r});
    x8(8'hE0); x8(8'h00); x8(8'hC3); slot; x8(8'hFF);
    chk("e0 data", 16'h0066, {8'h00, r});
    $display("memory test done");
  endtask : t_mem
  task automatic t_halted;
    halted_debug_mode = 1'b1;
    x8(8'h6B); slot; x8(8'hFF); h = r; x8(8'hFF);
    chk("progctr", 16'h1234, {h, r});
    x8(8'h4C); x8(8'h20); x8(8'h10); slot;
    chk("index load", 16'h2010, rw);
    chk("index sel", {13'h0000, REG_INDEX}, {13'h0000, rs});
    x8(8'h71); slot; x8(8'hFF); h = r; x8(8'hFF);
    chk("autoinc rd", 16'hC1A4, {h, r});
    x8(8'h50); x8(8'h77); slot;
    chk("autoinc wr", 16'h2001, wa);
    x8(8'hC2); x8(8'hBE); x8(8'hEF); x8(8'hE2); x8(8'hFF); h = r; x8(8'hFF);
    chk("match", 16'hBEEF, {h, r});
    x8(8'hD5); slot;
    chk("ack on", 16'h0001, {15'h0000, ack_enabled});
    x8(8'hD6); slot;
    chk("ack off", 16'h0000, {15'h0000, ack_enabled});
    x8(8'h10); slot; x8(8'h08); slot; x8(8'h18); slot;
    chk("steps", 16'h0001, n_step);
    chk("resumes", 16'h0002, n_res);
    $display("halted test done");
  endtask : t_halted
  task automatic t_timeout;
    x8(8'hC0); x8(8'h00);
    repeat (600) @(negedge clk_sys);
    x8(8'hE4); x8(8'hFF);
    chk("after abort", 16'h00C1, {8'h00, r});
    chk("no write", 16'h2001, wa);
    $display("timeout test done");
  endtask : t_timeout
  initial begin
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    repeat (600) @(negedge clk_sys);
    t_probe;
    t_ctrl;
    t_mem;
    t_halted;
    t_timeout;
    stop_test;
  end
  initial begin
    repeat (40000) @(negedge clk_sys);
    n_errors++;
    stop_test;
  end
endmodule : sdp_command_port_tb
`default_nettype wire
